// ===== include/spd_pkg.sv
package spd_pkg;
  localparam logic [7:0] SPD_CFG_OFFSET = 8'h9b;
  localparam int SPD_CFG_BYTES = 3;
  localparam logic [23:0] SPD_CFG_RESET = 24'h000000;
  localparam int SPD_SHAPE_HI = 23;
  localparam int SPD_SHAPE_LO = 20;
  localparam logic [3:0] SPD_SHAPE_FRAME = 4'hf;
  localparam int SPD_TYPE_BIT = 19;
  localparam int SPD_POL_BIT = 18;
  localparam int SPD_SEL_HI = 17;
  localparam int SPD_SEL_LO = 16;
  localparam int SPD_PERIOD_HI = 15;
  localparam logic [1:0] SPD_SEL_A = 2'h0;
  localparam logic [1:0] SPD_SEL_SELF = 2'h1;
  localparam logic [1:0] SPD_SEL_C = 2'h2;
  localparam logic [1:0] SPD_SEL_D = 2'h3;
  localparam logic [23:0] SPD_MAX_RATIO = 24'hefffff;
  typedef enum logic [2:0] {
    SPD_IDLE = 3'h1,
    SPD_DIV = 3'h2,
    SPD_FRAME = 3'h4
  } spd_state_t;
endpackage

// ===== src/spd_edge_sync.sv
`timescale 1ns/100ps
module spd_edge_sync
  import spd_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign rise_o = sync_reg & ~prev_reg;
endmodule

// ===== src/spd_postdiv.sv
`timescale 1ns/100ps
// Operation
// R1: shape field all ones selects frame pulse output instead of clock.
// R2: otherwise output 50% clock, oscillator divided by full 24-bit value; code holds ratio 1 high, ratio 0 low.
// R3: software keeps clock ratio at or below the documented maximum.
// R4: frame pulses spaced by low 16-bit count of related-clock periods.
// R5: select field picks sibling A, C or D; width is one period.
// R6: software never selects code 01, this divider itself.
// R7: polarity bit 0 gives normal pulse, 1 inverted pulse.
// R8: type 0 puts frame boundary at middle of pulse.
// R9: type 1 makes pulse edge mark the frame boundary.
// R10: polarity inverted when pulse routed to configurable output pin.
// R11: a register write restarts counting from the new settings.
module spd_postdiv
  import spd_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic wr_en_i,
  input wire logic [1:0] wr_byte_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [1:0] rd_byte_i,
  output logic [7:0] rd_data_o,
  input wire logic rel_clk_a_i,
  input wire logic rel_clk_c_i,
  input wire logic rel_clk_d_i,
  input wire logic pin_route_i,
  output logic postdivider_b_ratio_o,
  output logic frame_mode_o
);
  logic [23:0] cfg_reg;
  logic [23:0] cfg_next;
  logic [23:0] cnt_reg;
  logic [23:0] cnt_next;
  logic [15:0] per_reg;
  logic [15:0] per_next;
  logic out_reg;
  logic out_next;
  logic restart_reg;
  spd_state_t state_reg;
  spd_state_t state_next;
  logic a_lvl, c_lvl, d_lvl, a_rise, c_rise, d_rise;
  logic rel_rise;
  logic rel_lvl;
  logic pulse_raw;

  function automatic logic [23:0] spd_half(input logic [23:0] r);
    spd_half = r >> 1;
  endfunction

  spd_edge_sync u_sync_a (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .async_i(rel_clk_a_i),
    .level_o(a_lvl), .rise_o(a_rise));
  spd_edge_sync u_sync_c (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .async_i(rel_clk_c_i),
    .level_o(c_lvl), .rise_o(c_rise));
  spd_edge_sync u_sync_d (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .async_i(rel_clk_d_i),
    .level_o(d_lvl), .rise_o(d_rise));

  wire [3:0] shape = cfg_reg[SPD_SHAPE_HI:SPD_SHAPE_LO];
  wire is_frame = (shape == SPD_SHAPE_FRAME); // see R1
  wire [1:0] sel = cfg_reg[SPD_SEL_HI:SPD_SEL_LO];
  wire [15:0] period = cfg_reg[SPD_PERIOD_HI:0];
  // last count of a frame; period 0 acts as 1
  wire [15:0] per_last = (period == 16'h0000) ? 16'h0000 : period - 16'h0001;
  wire type_edge = cfg_reg[SPD_TYPE_BIT];
  wire pol_inv = cfg_reg[SPD_POL_BIT] ^ pin_route_i; // see R7 see R10

  // related clock choice; code 01 left dead (see R6)
  assign rel_rise = (sel == SPD_SEL_A) ? a_rise :
                    (sel == SPD_SEL_C) ? c_rise :
                    (sel == SPD_SEL_D) ? d_rise : 1'b0; // see R5
  assign rel_lvl = (sel == SPD_SEL_A) ? a_lvl :
                   (sel == SPD_SEL_C) ? c_lvl :
                   (sel == SPD_SEL_D) ? d_lvl : 1'b0;

  // register write, byte 0 = bits 7:0
  always_comb
  begin
    cfg_next = cfg_reg;
    if (wr_en_i)
    begin
      if (wr_byte_i == 2'h0)
        cfg_next[7:0] = wr_data_i;
      else if (wr_byte_i == 2'h1)
        cfg_next[15:8] = wr_data_i;
      else if (wr_byte_i == 2'h2)
        cfg_next[23:16] = wr_data_i;
    end
  end

  wire [7:0] rd_sel = (rd_byte_i == 2'h0) ? cfg_reg[7:0] :
                      (rd_byte_i == 2'h1) ? cfg_reg[15:8] :
                      (rd_byte_i == 2'h2) ? cfg_reg[23:16] : 8'h00;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    per_next = per_reg;
    out_next = out_reg;
    case (state_reg)
      SPD_IDLE:
      begin
        cnt_next = 24'h000000;
        per_next = 16'h0000;
        out_next = 1'b0;
        if (is_frame)
          state_next = SPD_FRAME;
        else if (cfg_reg != 24'h000000)
          state_next = SPD_DIV;
      end
      SPD_DIV:
      begin
        // toggle at half and full ratio; odd ratio high half rounds down, ratio 1 stays high
        if (cnt_reg >= cfg_reg - 24'h000001)
        begin
          cnt_next = 24'h000000;
          out_next = 1'b1;
        end
        else
        begin
          cnt_next = cnt_reg + 24'h000001;
          if (cnt_reg + 24'h000001 == spd_half(cfg_reg))
            out_next = 1'b0;
        end // see R2
      end
      SPD_FRAME:
      begin
        if (rel_rise)
        begin
          if (per_reg >= per_last)
            per_next = 16'h0000;
          else
            per_next = per_reg + 16'h0001; // see R4
        end
      end
      default:
        state_next = SPD_IDLE;
    endcase
    if (restart_reg)
      state_next = SPD_IDLE; // see R11
  end

  // frame pulse lasts one related period; straddle covers late half of last period and early half of period 0
  assign pulse_raw = type_edge ? (per_reg == 16'h0000) : // see R9
                     ((per_reg == per_last) & (~rel_lvl | rel_rise)) |
                     ((per_reg == 16'h0000) & rel_lvl & ~rel_rise); // see R8

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cfg_reg <= SPD_CFG_RESET;
      cnt_reg <= 24'h000000;
      per_reg <= 16'h0000;
      out_reg <= 1'b0;
      restart_reg <= 1'b0;
      state_reg <= SPD_IDLE;
    end
    else
    begin
      cfg_reg <= cfg_next;
      cnt_reg <= cnt_next;
      per_reg <= per_next;
      out_reg <= out_next;
      restart_reg <= wr_en_i;
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      postdivider_b_ratio_o <= 1'b0;
      frame_mode_o <= 1'b0;
      rd_data_o <= 8'h00;
    end
    else
    begin
      frame_mode_o <= is_frame;
      rd_data_o <= rd_sel;
      if (state_reg == SPD_FRAME)
        postdivider_b_ratio_o <= pulse_raw ^ pol_inv; // see R7
      else
        postdivider_b_ratio_o <= out_reg;
    end
  end

  property p_frame_state; // see R1
    @(posedge sys_clk_i) disable iff (reset_i)
      (state_reg == SPD_FRAME) |-> is_frame || $past(restart_reg) || restart_reg;
  endproperty
  a_frame_state: assert property (p_frame_state) else $error("frame state without frame shape"); // see R1

  property p_div_state; // see R2
    @(posedge sys_clk_i) disable iff (reset_i)
      (state_reg == SPD_DIV && !restart_reg && !$past(restart_reg)) |-> !is_frame;
  endproperty
  a_div_state: assert property (p_div_state) else $error("divider runs in frame shape"); // see R2

  property p_div_wrap; // see R2
    @(posedge sys_clk_i) disable iff (reset_i)
      (state_reg == SPD_DIV && state_next == SPD_DIV && cnt_reg >= cfg_reg - 24'h000001)
        |=> (cnt_reg == 24'h000000) && out_reg;
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("divider did not wrap"); // see R2

  property p_per_wrap; // see R4
    @(posedge sys_clk_i) disable iff (reset_i)
      (state_reg == SPD_FRAME && state_next == SPD_FRAME && rel_rise && per_reg == per_last)
        |=> per_reg == 16'h0000;
  endproperty
  a_per_wrap: assert property (p_per_wrap) else $error("frame count did not wrap"); // see R4

  property p_per_hold; // see R5
    @(posedge sys_clk_i) disable iff (reset_i)
      (state_reg == SPD_FRAME && state_next == SPD_FRAME && !rel_rise) |=> $stable(per_reg);
  endproperty
  a_per_hold: assert property (p_per_hold) else $error("frame count moved without related edge"); // see R5

  property p_polarity; // see R7
    @(posedge sys_clk_i) disable iff (reset_i)
      (state_reg == SPD_FRAME) |=> postdivider_b_ratio_o == ($past(pulse_raw) ^ $past(pol_inv));
  endproperty
  a_polarity: assert property (p_polarity) else $error("frame pulse polarity wrong"); // see R7 see R10

  sequence s_edge_at_boundary;
    !pulse_raw ##1 pulse_raw;
  endsequence
  property p_edge_type; // see R9
    @(posedge sys_clk_i) disable iff (reset_i)
      (type_edge && state_reg == SPD_FRAME && !restart_reg && !wr_en_i && rel_rise && per_reg == per_last
        && per_last != 16'h0000) |-> s_edge_at_boundary;
  endproperty
  a_edge_type: assert property (p_edge_type) else $error("edge type pulse misplaced"); // see R9

  sequence s_pulse_spans_boundary;
    pulse_raw ##1 pulse_raw;
  endsequence
  property p_straddle; // see R8
    @(posedge sys_clk_i) disable iff (reset_i)
      (!type_edge && state_reg == SPD_FRAME && !restart_reg && !wr_en_i && rel_rise && per_reg == per_last)
        |-> s_pulse_spans_boundary;
  endproperty
  a_straddle: assert property (p_straddle) else $error("straddle pulse broken at frame boundary"); // see R8

  sequence s_write;
    wr_en_i;
  endsequence
  sequence s_idle_reset;
    ##2 (state_reg == SPD_IDLE);
  endsequence
  property p_restart; // see R11
    @(posedge sys_clk_i) disable iff (reset_i)
      s_write |-> s_idle_reset;
  endproperty
  a_restart: assert property (p_restart) else $error("write did not restart divider"); // see R11
endmodule

// ===== test/test_synth_postdiv_frame_pulse.sv
`timescale 1ns/100ps
module test_synth_postdiv_frame_pulse
  import spd_pkg::*;
;
  typedef struct {logic [23:0] cfg; logic route; int win; int hi; int ri;} spd_row_t;
  localparam int LIMIT = 20000;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wr_en_i = 1'b0;
  logic [1:0] wr_byte_i = 2'h0;
  logic [7:0] wr_data_i = 8'h00;
  logic [1:0] rd_byte_i = 2'h0;
  logic [7:0] rd_data_o;
  logic [3:0] a_cnt = 4'h0;
  logic [3:0] c_cnt = 4'h0;
  logic pin_route_i = 1'b0;
  logic postdivider_b_ratio_o;
  logic frame_mode_o;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int hi;
  int ri;
  spd_row_t rows [9] = '{
    '{24'h000004, 1'b0, 40, 20, 10}, '{24'h000005, 1'b0, 50, 20, 10},
    '{24'h000001, 1'b0, 20, 20, 0}, '{24'h000000, 1'b0, 20, 0, 0},
    '{24'hf80003, 1'b0, 96, 32, 4}, '{24'hf60003, 1'b0, 144, 96, 4},
    '{24'hfb0002, 1'b1, 128, 64, 4}, '{24'hf40002, 1'b1, 64, 32, 4},
    '{24'hf20002, 1'b0, 96, 48, 4}};

  spd_postdiv dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .wr_en_i(wr_en_i), .wr_byte_i(wr_byte_i),
    .wr_data_i(wr_data_i), .rd_byte_i(rd_byte_i), .rd_data_o(rd_data_o), .rel_clk_a_i(a_cnt[2]),
    .rel_clk_c_i(c_cnt < 4'h6), .rel_clk_d_i(a_cnt[3]), .pin_route_i(pin_route_i),
    .postdivider_b_ratio_o(postdivider_b_ratio_o), .frame_mode_o(frame_mode_o));

  initial
  begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // sibling clocks: a period 8, c period 12, d period 16
  always_ff @(posedge sys_clk_i)
  begin
    a_cnt <= a_cnt + 4'h1;
    c_cnt <= (c_cnt == 4'hb) ? 4'h0 : c_cnt + 4'h1;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_errors++;
      $display("BAD %0t timeout", $time);
      finish_test();
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] b, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr_en_i <= 1'b1;
    wr_byte_i <= b;
    wr_data_i <= d;
    @(posedge sys_clk_i);
    wr_en_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [23:0] exp);
    for (int b = 0; b < 4; b++)
    begin
      @(posedge sys_clk_i);
      rd_byte_i <= 2'(b);
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk({16'h0, rd_data_o}, (b == 3) ? 24'h0 : {16'h0, exp[8*b+:8]}, "read byte");
    end
  endtask

  task automatic measure(input int win, output int h, output int r);
    logic prev;
    h = 0;
    r = 0;
    @(negedge sys_clk_i);
    prev = postdivider_b_ratio_o;
    repeat (win)
    begin
      @(negedge sys_clk_i);
      if (postdivider_b_ratio_o === 1'b1)
        h++;
      else if (postdivider_b_ratio_o !== 1'b0)
        h += 100000;
      if (postdivider_b_ratio_o === 1'b1 && prev === 1'b0)
        r++;
      prev = postdivider_b_ratio_o;
    end
  endtask

  initial
  begin
    repeat (3) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd_chk(SPD_CFG_RESET);
    chk({23'h0, postdivider_b_ratio_o}, 24'h0, "output after reset");
    $display("test reset done");
    foreach (rows[i])
    begin
      @(posedge sys_clk_i);
      pin_route_i <= rows[i].route;
      for (int b = 0; b < 3; b++)
        wr(2'(b), rows[i].cfg[8*b+:8]);
      rd_chk(rows[i].cfg);
      repeat (150) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk({23'h0, frame_mode_o}, {23'h0, rows[i].cfg[23:20] == SPD_SHAPE_FRAME}, "mode flag");
      measure(rows[i].win, hi, ri);
      chk(24'(hi), 24'(rows[i].hi), "high cycles");
      chk(24'(ri), 24'(rows[i].ri), "rising edges");
      $display("test row %0d done", i);
    end
    // byte index 3 is ignored
    wr(2'h3, 8'h55);
    rd_chk(rows[8].cfg);
    $display("test ignored byte done");
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    rd_chk(SPD_CFG_RESET);
    chk({23'h0, postdivider_b_ratio_o}, 24'h0, "output in reset");
    @(posedge sys_clk_i);
    reset_i <= 1'b0;
    measure(20, hi, ri);
    chk(24'(hi), 24'h0, "output after second reset");
    $display("test second reset done");
    finish_test();
  end
endmodule
